// ### hdl/pllc_divider.sv
// Programmable tick divider: one output pulse per period input ticks
`default_nettype none

module pllc_divider (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    // Control
    input wire logic restart,
    input wire logic [11:0] period,
    // Ticks
    input wire logic tick_in,
    output logic tick_out
);
    import pllc_pkg::*;

    pllc_dstate_t st_r;
    pllc_dstate_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (restart) begin
            st_nxt.cnt = '0;
        end else if (tick_in) begin
            // A shrunken period must not strand the count above it
            if (st_r.cnt >= period - 12'h001) begin
                st_nxt.cnt = '0;
                st_nxt.tick = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + 12'h001;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign tick_out = st_r.tick;

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    period_end_a: assert property (
        (ce && !restart && tick_in && st_r.cnt >= period - 12'h001)
        |=> (tick_out && st_r.cnt == 12'h000))
        else $error("divider missed period end");

endmodule

`default_nettype wire

// ### hdl/pllc_sync.sv
// Two-flop synchroniser for a pin input
`default_nettype none

module pllc_sync (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    // Data
    input wire logic d,
    output logic q
);
    import pllc_pkg::*;

    pllc_sstate_t st_r;
    pllc_sstate_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.s2;

endmodule

`default_nettype wire

// ### hdl/pllc_top.sv
// Clock and PLL control: registers, lock timing, glitch-free core clock switch
//
// Added by the designer: the register offsets and the APB slave port.
`default_nettype none
`include "pllc_regs.svh"

module pllc_top #(
    parameter int unsigned LOCK_CYCLES = `PLLC_LOCK_CYCLES
) (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    // Register bus
    input wire pllc_pkg::pllc_apb_req_t apb_req,
    output var pllc_pkg::pllc_apb_rsp_t apb_rsp,
    // Analog loop
    input wire logic osc_in,
    output logic pd_up,
    output logic pd_dn,
    output logic pll_pwrdn,
    // Derived clocks
    output var pllc_pkg::pllc_clk_t clk_out,
    // Auxiliary pins
    input wire logic [3:0] dbg_func,
    input wire logic [3:0] sec_func,
    output logic [3:0] aux_pin
);
    import pllc_pkg::*;

    // ******************************
    // State and decode
    // ******************************
    pllc_state_t st_r;
    pllc_state_t st_nxt;

    logic setup;
    logic access;
    logic hit_ctrl;
    logic hit_div;
    logic hit_stat;
    logic mapped;
    logic wr_ctrl;
    logic wr_div;
    logic reprog;
    logic ref_in;
    logic osc_q;
    logic osc_edge;
    logic fb_restart;
    logic core_div_tick;
    logic [11:0] ref_period;
    logic [11:0] fb_period;
    logic [11:0] core_period;
    logic [2:0] out_factor;
    logic [3:0] core_factor;
    logic [31:0] rd_word;

    assign setup = apb_req.psel && !apb_req.penable;
    assign access = apb_req.psel && apb_req.penable;
    assign hit_ctrl = apb_req.paddr == `PLLC_CTRL_OFS;
    assign hit_div = apb_req.paddr == `PLLC_DIV_OFS;
    assign hit_stat = apb_req.paddr == `PLLC_STAT_OFS;
    assign mapped = hit_ctrl || hit_div || hit_stat;
    assign wr_ctrl = access && apb_req.pwrite && hit_ctrl;
    assign wr_div = access && apb_req.pwrite && hit_div;

    // ******************************
    // Reprogram detection
    // ******************************
    // Halving changes the loop input as much as a divider write does
    assign reprog = wr_div || st_r.ctrl.pwrdn
        || (wr_ctrl && apb_req.pwdata[`PLLC_HALVE_BIT] != st_r.ctrl.halve);

    // ******************************
    // Loop dividers
    // ******************************
    assign ref_in = st_r.ctrl.halve ? st_r.half : 1'b1;
    assign ref_period = {4'h0, st_r.div.ref_div} + 12'h002;
    assign fb_period = {3'h0, st_r.div.fb_div} + 12'h002;
    assign fb_restart = reprog;

    // Oscillator edges are only seen while slower than half of mclk
    pllc_sync u_osc_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .d(osc_in),
        .q(osc_q)
    );

    assign osc_edge = osc_q && !st_r.osc_prev;

    pllc_divider u_ref_div (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .restart(fb_restart),
        .period(ref_period),
        .tick_in(ref_in),
        .tick_out(pd_up)
    );

    pllc_divider u_fb_div (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .restart(fb_restart),
        .period(fb_period),
        .tick_in(osc_edge),
        .tick_out(pd_dn)
    );

    // ******************************
    // Core divider
    // ******************************
    assign out_factor = {1'b0, st_r.div.out_div} + 3'h1;
    assign core_factor = (st_r.div.core_div == 4'h0) ? 4'h1 : st_r.div.core_div;
    assign core_period = 12'(out_factor * core_factor);

    pllc_divider u_core_div (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .restart(fb_restart),
        .period(core_period),
        .tick_in(osc_edge),
        .tick_out(core_div_tick)
    );

    // ******************************
    // Read mux
    // ******************************
    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit_ctrl) begin
            rd_word[`PLLC_LOCK_BIT] = st_r.lock;
            rd_word[`PLLC_DAC_HI:`PLLC_DAC_LO] = st_r.ctrl.dac_sel;
            rd_word[`PLLC_HALVE_BIT] = st_r.ctrl.halve;
            rd_word[`PLLC_AUDIO_BIT] = st_r.ctrl.audio_sel;
            rd_word[`PLLC_PINSEL_BIT] = st_r.ctrl.pin_sel;
            rd_word[`PLLC_PWRDN_BIT] = st_r.ctrl.pwrdn;
            rd_word[`PLLC_PLLEN_BIT] = st_r.ctrl.pll_en;
        end else if (hit_div) begin
            rd_word[`PLLC_FB_HI:`PLLC_FB_LO] = st_r.div.fb_div;
            rd_word[`PLLC_REF_HI:`PLLC_REF_LO] = st_r.div.ref_div;
            rd_word[`PLLC_OUT_HI:`PLLC_OUT_LO] = st_r.div.out_div;
            rd_word[`PLLC_CORE_HI:`PLLC_CORE_LO] = st_r.div.core_div;
        end else if (hit_stat) begin
            rd_word[3:2] = st_r.mode;
            rd_word[1] = st_r.mode == ST_PLL;
            rd_word[0] = st_r.lock;
        end
    end

    // ******************************
    // Next state
    // ******************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.half = !st_r.half;
        st_nxt.osc_prev = osc_q;

        // Zero wait states; answer latched in the setup cycle
        st_nxt.rsp.pready = 1'b1;
        if (setup) begin
            st_nxt.rsp.prdata = apb_req.pwrite ? 32'h0000_0000 : rd_word;
            st_nxt.rsp.pslverr = !mapped || (apb_req.paddr[1:0] != 2'b00);
        end

        if (wr_ctrl) begin
            st_nxt.ctrl.dac_sel = apb_req.pwdata[`PLLC_DAC_HI:`PLLC_DAC_LO];
            st_nxt.ctrl.halve = apb_req.pwdata[`PLLC_HALVE_BIT];
            st_nxt.ctrl.audio_sel = apb_req.pwdata[`PLLC_AUDIO_BIT];
            st_nxt.ctrl.pin_sel = apb_req.pwdata[`PLLC_PINSEL_BIT];
            st_nxt.ctrl.pwrdn = apb_req.pwdata[`PLLC_PWRDN_BIT];
            st_nxt.ctrl.pll_en = apb_req.pwdata[`PLLC_PLLEN_BIT];
        end
        if (wr_div) begin
            st_nxt.div.fb_div = apb_req.pwdata[`PLLC_FB_HI:`PLLC_FB_LO];
            st_nxt.div.ref_div = apb_req.pwdata[`PLLC_REF_HI:`PLLC_REF_LO];
            st_nxt.div.out_div = apb_req.pwdata[`PLLC_OUT_HI:`PLLC_OUT_LO];
            st_nxt.div.core_div = apb_req.pwdata[`PLLC_CORE_HI:`PLLC_CORE_LO];
        end

        // Lock wait counts crystal cycles, sized for the fastest input
        if (reprog) begin
            st_nxt.lock = 1'b0;
            st_nxt.lock_cnt = '0;
        end else if (!st_r.lock) begin
            if (st_r.lock_cnt >= 18'(LOCK_CYCLES - 1)) begin
                st_nxt.lock = 1'b1;
            end else begin
                st_nxt.lock_cnt = st_r.lock_cnt + 18'h00001;
            end
        end

        // Switch to the PLL happens only at a core period boundary; the fall back to bypass is immediate
        unique case (st_r.mode)
            ST_BYPASS: begin
                if (st_r.ctrl.pll_en) begin
                    st_nxt.mode = ST_WAIT_LOCK;
                end
            end
            ST_WAIT_LOCK: begin
                if (!st_r.ctrl.pll_en) begin
                    st_nxt.mode = ST_BYPASS;
                end else if (st_r.lock && core_div_tick) begin
                    st_nxt.mode = ST_PLL;
                end
            end
            ST_PLL: begin
                // Dropping lock falls back to the crystal at once
                if (!st_r.ctrl.pll_en || !st_r.lock) begin
                    st_nxt.mode = ST_BYPASS;
                end
            end
        endcase

        st_nxt.clk.core_tick = (st_r.mode == ST_PLL) ? core_div_tick : 1'b1;
        st_nxt.clk.dac_two = st_r.ctrl.dac_sel[1] ? st_r.half : 1'b1;
        st_nxt.clk.dac_one = st_r.ctrl.dac_sel[0] ? 1'b1 : st_r.half;
        st_nxt.clk.audio = st_r.ctrl.audio_sel ? 1'b1 : st_r.half;
        st_nxt.aux = st_r.ctrl.pin_sel ? sec_func : dbg_func;
    end

    // ******************************
    // State register
    // ******************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.ctrl <= pllc_ctrl_t'(8'h00);
            // Core divider field 1, all loop dividers 0
            st_r.div <= pllc_div_t'(23'h08_0000);
            st_r.mode <= ST_BYPASS;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign apb_rsp = st_r.rsp;
    assign clk_out = st_r.clk;
    assign aux_pin = st_r.aux;
    assign pll_pwrdn = st_r.ctrl.pwrdn;

    // ******************************
    // Checks
    // ******************************
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_switch_point;
        ce && st_r.mode == ST_WAIT_LOCK && st_r.ctrl.pll_en && st_r.lock && core_div_tick;
    endsequence

    sequence s_read_ctrl;
        ce && setup && !apb_req.pwrite && hit_ctrl;
    endsequence

    sequence s_halved_tick;
        ce && st_r.ctrl.halve && ref_in ##1 ce && st_r.ctrl.halve;
    endsequence

    glitch_free_a: assert property (s_switch_point |=> st_r.mode == ST_PLL)
        else $error("pll switch missed period boundary");

    no_early_pll_a: assert property (
        (ce && st_r.mode != ST_PLL && !(st_r.lock && core_div_tick))
        |=> st_r.mode != ST_PLL)
        else $error("core moved to pll before lock");

    bypass_core_a: assert property (
        (ce && st_r.mode != ST_PLL) |=> clk_out.core_tick)
        else $error("bypass core clock not crystal");

    pll_core_a: assert property (
        (ce && st_r.mode == ST_PLL) |=> clk_out.core_tick == $past(core_div_tick))
        else $error("pll core clock not from divider");

    lock_read_a: assert property (
        s_read_ctrl |=> apb_rsp.prdata[31] == $past(st_r.lock))
        else $error("lock bit not at bit 31");

    lock_drop_a: assert property (wr_div && ce |=> !st_r.lock)
        else $error("lock kept after divider write");

    lock_time_a: assert property (
        $rose(st_r.lock) |-> $past(st_r.lock_cnt) == 18'(LOCK_CYCLES - 1))
        else $error("lock rose at wrong count");

    halve_in_a: assert property (s_halved_tick |-> !ref_in)
        else $error("halved input not every second tick");

    audio_sel_a: assert property (
        (ce && st_r.ctrl.audio_sel) |=> clk_out.audio)
        else $error("audio clock not crystal rate");

    dac_two_a: assert property (
        (ce && !st_r.ctrl.dac_sel[1]) |=> clk_out.dac_two)
        else $error("dac clock two not crystal rate");

    pin_route_a: assert property (
        (ce && st_r.ctrl.pin_sel) |=> aux_pin == $past(sec_func))
        else $error("secondary pin functions not routed");

    bypass_idle_a: assert property (
        (ce && !st_r.ctrl.pll_en) |=> st_r.mode == ST_BYPASS)
        else $error("not in bypass while pll disabled");

    pwrdn_drop_a: assert property (
        (ce && st_r.ctrl.pwrdn) |=> !st_r.lock)
        else $error("lock kept while powered down");

    halve_drop_a: assert property (
        (ce && wr_ctrl && apb_req.pwdata[`PLLC_HALVE_BIT] != st_r.ctrl.halve) |=> !st_r.lock)
        else $error("lock kept after input halving change");

    dac_one_a: assert property (
        (ce && st_r.ctrl.dac_sel[0]) |=> clk_out.dac_one)
        else $error("dac clock one not crystal rate");

    dac_one_half_a: assert property (
        (ce && !st_r.ctrl.dac_sel[0]) |=> clk_out.dac_one == $past(st_r.half))
        else $error("dac clock one not half rate");

    audio_half_a: assert property (
        (ce && !st_r.ctrl.audio_sel) |=> clk_out.audio == $past(st_r.half))
        else $error("audio clock not half rate");

endmodule

`default_nettype wire

// ### shared/pllc_pkg.sv
// Types shared by the clock and PLL control block
`default_nettype none
`include "pllc_regs.svh"

package pllc_pkg;

    typedef enum logic [1:0] {ST_BYPASS, ST_WAIT_LOCK, ST_PLL} pllc_mode_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } pllc_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } pllc_apb_rsp_t;

    typedef struct packed {
        logic [2:0] dac_sel;
        logic halve;
        logic audio_sel;
        logic pin_sel;
        logic pwrdn;
        logic pll_en;
    } pllc_ctrl_t;

    typedef struct packed {
        logic [3:0] core_div;
        logic [1:0] out_div;
        logic [7:0] ref_div;
        logic [8:0] fb_div;
    } pllc_div_t;

    typedef struct packed {
        logic core_tick;
        logic dac_one;
        logic dac_two;
        logic audio;
    } pllc_clk_t;

    typedef struct packed {
        logic [11:0] cnt;
        logic tick;
    } pllc_dstate_t;

    typedef struct packed {
        logic s1;
        logic s2;
    } pllc_sstate_t;

    typedef struct packed {
        pllc_mode_t mode;
        pllc_ctrl_t ctrl;
        pllc_div_t div;
        logic lock;
        logic [17:0] lock_cnt;
        logic half;
        logic osc_prev;
        pllc_clk_t clk;
        logic [3:0] aux;
        pllc_apb_rsp_t rsp;
    } pllc_state_t;

endpackage

`default_nettype wire

// ### shared/pllc_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef PLLC_REGS_SVH
`define PLLC_REGS_SVH

// ******************************
// Register offsets (byte address)
// ******************************
`define PLLC_CTRL_OFS 8'h00
`define PLLC_DIV_OFS 8'h04
`define PLLC_STAT_OFS 8'h08

// ******************************
// Control register fields
// ******************************
`define PLLC_LOCK_BIT 31
`define PLLC_DAC_HI 30
`define PLLC_DAC_LO 28
`define PLLC_HALVE_BIT 23
`define PLLC_AUDIO_BIT 22
`define PLLC_PINSEL_BIT 4
`define PLLC_PWRDN_BIT 1
`define PLLC_PLLEN_BIT 0

// ******************************
// Divider register fields
// ******************************
`define PLLC_FB_HI 8
`define PLLC_FB_LO 0
`define PLLC_REF_HI 19
`define PLLC_REF_LO 12
`define PLLC_OUT_HI 25
`define PLLC_OUT_LO 24
`define PLLC_CORE_HI 31
`define PLLC_CORE_LO 28

// ******************************
// Reset values and timing
// ******************************
`define PLLC_CTRL_RST 32'h0000_0000
`define PLLC_DIV_RST 32'h1000_0000
`define PLLC_CLK_MHZ 25
// Kept just under the 10 ms lock limit, counter end included
`define PLLC_LOCK_TIME_US 9900
`define PLLC_LOCK_CYCLES (`PLLC_LOCK_TIME_US * `PLLC_CLK_MHZ)

`endif

// ### verification/pllc_osc_model.sv
// Behavioural oscillator standing in for the analog loop
`default_nettype none

module pllc_osc_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Loop control
    input wire logic pwrdn,
    input wire logic [3:0] half_per,
    // Oscillator
    output logic osc_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_r;
    // Powered-down loop is silent, so no stale edges reach the dividers
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n || pwrdn) begin
            cnt_r <= 4'h0;
            osc_in <= 1'b0;
        end else if (cnt_r >= half_per) begin
            cnt_r <= 4'h0;
            osc_in <= ~osc_in;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
endmodule

`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for the clock and PLL control block
`default_nettype none
`include "pllc_regs.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import pllc_pkg::*;
    // ******************************
    // Signals and instances
    // ******************************
    localparam int LOCK_N = 20;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    pllc_apb_req_t apb_req = '0;
    pllc_apb_rsp_t apb_rsp;
    logic osc_in, pd_up, pd_dn, pll_pwrdn;
    pllc_clk_t clk_out;
    logic [3:0] dbg_func = 4'h0;
    logic [3:0] sec_func = 4'h0;
    logic [3:0] aux_pin;
    logic [3:0] half_per = 4'h1;
    logic [15:0] lfsr = 16'h0003;
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;
    int cnt[6];
    logic [32:0] notes[$];

    always #20 mclk = ~mclk;

    pllc_top #(.LOCK_CYCLES(LOCK_N)) i_pllc_top (.mclk(mclk), .rst_n(rst_n), .ce(ce),
        .apb_req(apb_req), .apb_rsp(apb_rsp), .osc_in(osc_in), .pd_up(pd_up), .pd_dn(pd_dn),
        .pll_pwrdn(pll_pwrdn), .clk_out(clk_out), .dbg_func(dbg_func), .sec_func(sec_func),
        .aux_pin(aux_pin));
    pllc_osc_model i_pllc_osc_model (.mclk(mclk), .rst_n(rst_n), .pwrdn(pll_pwrdn),
        .half_per(half_per), .osc_in(osc_in));

    // ******************************
    // Tasks
    // ******************************
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic check(input string what, input logic [32:0] exp, input logic [32:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        $display("checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Expected read word is {pslverr, prdata}, noted at the setup edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] exp);
        @(posedge mclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        if (!wr) notes.push_back(exp);
        @(posedge mclk);
        apb_req.penable <= 1'b1;
        do @(posedge mclk); while (apb_rsp.pready !== 1'b1);
        apb_req <= '0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] exp);
        apb(1'b0, a, 32'h0, exp);
    endtask

    // Counts high cycles of each tick stream; lets register writes land first
    task automatic sample(input int n);
        cnt = '{default: 0};
        repeat (2) @(posedge mclk);
        repeat (n) begin
            @(negedge mclk);
            cnt[0] += int'(clk_out.core_tick === 1'b1);
            cnt[1] += int'(pd_up === 1'b1);
            cnt[2] += int'(pd_dn === 1'b1);
            cnt[3] += int'(clk_out.dac_one === 1'b1);
            cnt[4] += int'(clk_out.dac_two === 1'b1);
            cnt[5] += int'(clk_out.audio === 1'b1);
        end
    endtask

    // ******************************
    // Monitor, random pins, timeout
    // ******************************
    always @(posedge mclk) begin
        if (apb_req.psel && apb_req.penable && !apb_req.pwrite && apb_rsp.pready === 1'b1) begin
            if (notes.size() == 0) check("read without note", 33'h0, 33'h1_FFFF_FFFF);
            else check("read data", notes.pop_front(), {apb_rsp.pslverr, apb_rsp.prdata});
        end
    end

    always @(posedge mclk) begin
        lfsr <= lfsr_next(lfsr);
        dbg_func <= lfsr[3:0];
        sec_func <= lfsr[7:4];
        cycles++;
        // Whole run needs about 940 cycles
        if (cycles > 4000) begin
            fails++;
            $display("timeout after %0d cycles", cycles);
            close_out();
        end
    end

    // ******************************
    // Main sequence
    // ******************************
    initial begin
        logic [31:0] v;
        logic [3:0] e;
        logic h;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        rd(`PLLC_CTRL_OFS, 33'h0);
        rd(`PLLC_DIV_OFS, {1'b0, `PLLC_DIV_RST});
        rd(`PLLC_STAT_OFS, 33'h0);
        sample(8);
        check("bypass core ticks", 33'(8), 33'(cnt[0]));
        wr(8'h0C, 32'hFFFF_FFFF);
        rd(8'h0C, {1'b1, 32'h0});
        rd(8'h02, {1'b1, 32'h0});
        $display("test reset and refusal done");
        // Power-down held so lock stays low whatever the random word holds
        v = {lfsr, lfsr_next(lfsr)} | 32'h8000_0002;
        wr(`PLLC_CTRL_OFS, v);
        @(negedge mclk);
        check("power-down pin", 33'h1, {32'h0, pll_pwrdn});
        rd(`PLLC_CTRL_OFS, {1'b0, v & 32'h70C0_0013});
        rd(`PLLC_STAT_OFS, {30'h0, v[0], 2'b00});
        sample(8);
        check("waiting core ticks", 33'(8), 33'(cnt[0]));
        $display("test control register done");
        for (int i = 0; i < 8; i++) begin
            wr(`PLLC_CTRL_OFS, {1'b0, i[2:0], 4'h0, 1'b1, i[0] ^ i[2], 22'h0});
            sample(4);
            check("dac two", i[1] ? 33'(2) : 33'(4), 33'(cnt[4]));
            check("dac one", i[0] ? 33'(4) : 33'(2), 33'(cnt[3]));
            check("audio", (i[0] ^ i[2]) ? 33'(4) : 33'(2), 33'(cnt[5]));
        end
        $display("test dac and audio selects done");
        for (int s = 0; s < 2; s++) begin
            wr(`PLLC_CTRL_OFS, {27'h0, s[0], 4'h0});
            repeat (2) @(posedge mclk);
            repeat (6) begin
                @(posedge mclk);
                e = s ? sec_func : dbg_func;
                @(negedge mclk);
                check("aux pins", {29'h0, e}, {29'h0, aux_pin});
            end
        end
        $display("test pin select done");
        // Fast then slow oscillator; halving off then on
        for (int sp = 0; sp < 2; sp++) begin
            half_per <= sp ? 4'h2 : 4'h1;
            h = sp[0];
            wr(`PLLC_CTRL_OFS, {8'h0, h, 23'h0});
            wr(`PLLC_DIV_OFS, 32'h4100_1006);
            wr(`PLLC_CTRL_OFS, {8'h0, h, 22'h0, 1'b1});
            rd(`PLLC_STAT_OFS, 33'h4);
            sample(8);
            check("core ticks before lock", 33'(8), 33'(cnt[0]));
            repeat (150) @(posedge mclk);
            rd(`PLLC_STAT_OFS, 33'hB);
            rd(`PLLC_CTRL_OFS, {2'b01, 7'h0, h, 22'h0, 1'b1});
            sample(192);
            check("feedback ticks seen", 33'h1, 33'(cnt[2] > 2));
            check("core vs feedback", 33'h1, 33'((cnt[0] - cnt[2]) inside {[-1:1]}));
            check("reference rate", 33'h1,
                  33'((cnt[1] - (h ? 32 : 64)) inside {[-1:1]}));
            wr(`PLLC_CTRL_OFS, {8'h0, h, 23'h0});
            sample(8);
            check("core ticks after leaving", 33'(8), 33'(cnt[0]));
            rd(`PLLC_STAT_OFS, 33'h1);
        end
        $display("test lock and switch done");
        close_out();
    end
endmodule

`default_nettype wire
